/* rstpin_defines.vh */
`ifndef RSTPIN_DEFINES_VH
`define RSTPIN_DEFINES_VH
// port subregister indices written to the port address register
`define SUB_ALT_FUNC       8'h02
`define SUB_OPEN_DRAIN     8'h03
// reset values
`define ALT_FUNC_RST       8'h00
`define ALT_FUNC_RST_SMALL 8'h04
`define OPEN_DRAIN_RST     8'h00
// pin positions on port a
`define PIN_DBG            0
`define PIN_XTAL2          1
`define PIN_RST            2
// external reset qualification: four cycles always resets
`define EXT_RST_CYCLES     3'd4
// stop recovery delays in oscillator cycles
`define SMR_CYC_NO_XTAL    13'd66
`define SMR_CYC_XTAL       13'd5000
// oscillator control reset value (internal oscillator selected)
`define OSC_CTL_RST        8'h00
`define OSC_XTAL_EN_BIT    7
// watchdog control field positions
`define WDT_EXT_BIT        0
`define WDT_STOPREC_BIT    1
// reset cause field positions
`define CAUSE_POR_BIT      7
`define CAUSE_STOP_BIT     6
`define CAUSE_WDT_BIT      5
`define CAUSE_EXT_BIT      4
`define CAUSE_BO_BIT       3
`endif

/* rst_hold_counter.v */
`timescale 1ns/1ps
// small down-counter: loads a cycle count, reports busy while nonzero
module rst_hold_counter (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_load,   // one-cycle load strobe
  input  wire [12:0] i_count,  // cycles to hold
  input  wire        i_tick,   // count enable
  output reg         o_busy    // high while counting
);
  reg [12:0] cnt_q; // remaining cycles

  // load wins over counting so a new cause restarts the hold
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q  <= 13'h0000;
      o_busy <= 1'b0;
    end else if (i_load) begin
      cnt_q  <= i_count;
      o_busy <= (i_count != 13'h0000);
    end else if (i_tick && cnt_q != 13'h0000) begin
      cnt_q  <= cnt_q - 13'h0001;
      o_busy <= (cnt_q != 13'h0001);
    end
  end
endmodule

/* reset_and_port_pin_control.v */
`timescale 1ns/1ps
`include "rstpin_defines.vh"
module reset_and_port_pin_control #(
  parameter        SMALL_PKG    = 1'b1,   // smallest package: pins shared
  parameter [12:0] POR_HOLD     = 13'd66, // power-on indicator hold cycles
  parameter [12:0] BO_HOLD      = 13'd66, // brownout indicator hold cycles
  parameter [12:0] WDT_HOLD     = 13'd66  // watchdog indicator hold cycles
) (
  input  wire       i_clk,
  input  wire       i_rst,
  input  wire       i_rst_pin_in,    // level seen on the reset pin
  input  wire       i_por_evt,       // power-on event pulse
  input  wire       i_bo_evt,        // brownout event pulse
  input  wire       i_wdt_evt,       // watchdog reset event pulse
  input  wire       i_dbg_rst_wr,    // debugger writes reset-request bit
  input  wire       i_stop_exec,     // processor executes stop
  input  wire       i_wake,          // stop recovery source
  input  wire       i_osc_tick,      // internal oscillator cycle enable
  input  wire       i_unlock_seen,   // debug unlock pattern detected
  input  wire [7:0] i_port_addr,     // port address register value
  input  wire       i_port_ctl_wr,   // write strobe to port control reg
  input  wire [7:0] i_port_ctl_wdata,// port control write data
  input  wire       i_osc_ctl_wr,    // oscillator control write strobe
  input  wire [7:0] i_osc_ctl_wdata, // oscillator control write data
  input  wire       i_flag_clr,      // software clears reset flags
  input  wire [7:0] i_gpio_out,      // gpio output data
  input  wire [7:0] i_gpio_dir_in,   // direction bits, 1 = input
  input  wire [7:0] i_alt_out,       // alternate function outputs
  input  wire [7:0] i_alt_oe,        // alternate function output enables
  output reg        o_sys_rst,       // system reset to chip, not debugger
  output reg        o_cpu_rst,       // processor held in reset
  output reg        o_stopped,       // in stop state
  output reg        o_rst_pin_out,   // reset pin output value (always 0)
  output reg        o_rst_pin_oe,    // reset pin drive low enable
  output reg        o_dbg_req_bit,   // debugger reset-request bit
  output reg        o_dbg_unlocked,  // debug function unlocked
  output reg [7:0]  o_wdt_ctl,       // watchdog control flags
  output reg [7:0]  o_rst_cause,     // reset cause flags
  output reg [7:0]  o_osc_ctl,       // oscillator control value
  output reg [7:0]  o_alt_func,      // alt function enable register
  output reg [7:0]  o_open_drain,    // open drain control register
  output reg [7:0]  o_port_ctl_rdata,// port control read data
  output reg [7:0]  o_pin_out,       // per-pin output value
  output reg [7:0]  o_pin_oe         // per-pin output enable
);
  localparam ST_RUN   = 2'd0; // normal running
  localparam ST_RESET = 2'd1; // system reset active
  localparam ST_STOP  = 2'd2; // stop low-power state
  localparam ST_SMR   = 2'd3; // stop recovery delay

  reg [1:0]  st_q;            // top state
  reg [2:0]  low_cnt_q;       // consecutive low cycles on reset pin
  reg        ext_hold_q;      // external reset qualified, pin still low
  reg        int_pend_q;      // internal reset source pending hold
  reg        dbg_pend_q;      // debugger reset pending
  wire       hold_busy;       // indicator hold still counting
  reg        hold_load;       // load hold counter
  reg [12:0] hold_val;        // cycles to load
  reg        hold_tick;       // hold counter enable
  reg        ind_load;        // hold loaded for a reset, not a recovery
  wire       xtal_en;         // crystal oscillator enabled
  wire [7:0] alt_rst;         // alt function reset value
  wire [7:0] od_pin_mask;     // pins taken from gpio
  reg  [7:0] pin_out_d;       // next pin output
  reg  [7:0] pin_oe_d;        // next pin enable

  // pick the larger hold so that any cause gets its full delay
  function [12:0] max13;
    input [12:0] a;
    input [12:0] b;
    begin
      max13 = (a > b) ? a : b;
    end
  endfunction

  assign xtal_en     = o_osc_ctl[`OSC_XTAL_EN_BIT];
  assign alt_rst     = SMALL_PKG ? `ALT_FUNC_RST_SMALL : `ALT_FUNC_RST;
  assign od_pin_mask = xtal_en ? 8'hfc : 8'hff;

  // hold load: internal causes use parameters, stop recovery uses oscillator choice
  always @* begin
    hold_load = 1'b0;
    hold_val  = 13'h0000;
    hold_tick = 1'b1;
    ind_load  = 1'b0;
    // an external entry loads a one-cycle indicator pulse
    if (i_por_evt || i_bo_evt || i_wdt_evt || (o_dbg_req_bit && st_q == ST_RUN) ||
        (ext_hold_q && st_q != ST_RESET)) begin
      hold_load = 1'b1;
      ind_load  = 1'b1;
      hold_val  = max13(i_por_evt | o_dbg_req_bit ? POR_HOLD : 13'h0001,
                        max13(i_bo_evt ? BO_HOLD : 13'h0001,
                              i_wdt_evt ? WDT_HOLD : 13'h0001));
    end else if (st_q == ST_STOP && i_wake) begin
      hold_load = 1'b1;
      hold_val  = xtal_en ? `SMR_CYC_XTAL : `SMR_CYC_NO_XTAL;
    end
    if (st_q == ST_SMR) begin
      hold_tick = i_osc_tick; // stop delay counts oscillator cycles
    end
  end

  rst_hold_counter u_hold (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_load  (hold_load),
    .i_count (hold_val),
    .i_tick  (hold_tick),
    .o_busy  (hold_busy)
  );

  // external pin filter: count low cycles, qualify at three
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      low_cnt_q  <= 3'd0;
      ext_hold_q <= 1'b0;
    end else if (i_rst_pin_in) begin
      low_cnt_q  <= 3'd0;
      ext_hold_q <= 1'b0;
    end else begin
      if (low_cnt_q != `EXT_RST_CYCLES) begin
        low_cnt_q <= low_cnt_q + 3'd1;
      end
      // three low cycles already qualify: three may reset, four always does
      if (low_cnt_q >= 3'd2) begin
        ext_hold_q <= 1'b1;
      end
    end
  end

  // top sequencer: reset, run, stop, recovery
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q           <= ST_RESET;
      o_sys_rst      <= 1'b1;
      o_cpu_rst      <= 1'b1;
      o_stopped      <= 1'b0;
      int_pend_q     <= 1'b1;
      dbg_pend_q     <= 1'b0;
      o_dbg_req_bit  <= 1'b0;
      o_dbg_unlocked <= 1'b0;
      o_wdt_ctl      <= 8'h00;
      o_rst_cause    <= 8'h80;
      o_osc_ctl      <= `OSC_CTL_RST;
      o_alt_func     <= `ALT_FUNC_RST;
      o_open_drain   <= `OPEN_DRAIN_RST;
    end else begin
      // debugger bit set by write; it is cleared by the reset it starts
      if (i_dbg_rst_wr && st_q != ST_RESET) begin
        o_dbg_req_bit <= 1'b1;
      end
      if (i_flag_clr) begin
        o_wdt_ctl   <= 8'h00;
        o_rst_cause <= 8'h00;
      end
      case (st_q)
        ST_RUN: begin
          if (ext_hold_q || i_por_evt || i_bo_evt || i_wdt_evt || o_dbg_req_bit) begin
            st_q       <= ST_RESET;
            o_sys_rst  <= 1'b1;
            o_cpu_rst  <= 1'b1;
            int_pend_q <= ~ext_hold_q;
            dbg_pend_q <= o_dbg_req_bit;
          end else if (i_stop_exec) begin
            st_q      <= ST_STOP;
            o_stopped <= 1'b1;
            o_cpu_rst <= 1'b1;
          end
        end
        ST_RESET: begin
          o_dbg_req_bit <= 1'b0;
          // reset state restores port and oscillator registers
          o_alt_func    <= alt_rst;
          o_open_drain  <= `OPEN_DRAIN_RST;
          o_osc_ctl     <= `OSC_CTL_RST;
          // a debugger-started reset leaves the debugger's own state alone
          if (!dbg_pend_q) begin
            o_dbg_unlocked <= SMALL_PKG && i_unlock_seen;
          end
          if (!ext_hold_q && !hold_busy && !hold_load && i_rst_pin_in) begin
            st_q      <= ST_RUN;
            o_sys_rst <= 1'b0;
            o_cpu_rst <= 1'b0;
            if (!int_pend_q) begin
              o_wdt_ctl[`WDT_EXT_BIT]     <= 1'b1;
              o_rst_cause[`CAUSE_EXT_BIT] <= 1'b1;
            end
            if (dbg_pend_q) begin
              o_rst_cause[`CAUSE_POR_BIT] <= 1'b1;
            end
            int_pend_q <= 1'b0;
            dbg_pend_q <= 1'b0;
          end
        end
        ST_STOP: begin
          if (ext_hold_q || i_por_evt || i_bo_evt || i_wdt_evt) begin
            st_q       <= ST_RESET;
            o_stopped  <= 1'b0;
            o_sys_rst  <= 1'b1;
            int_pend_q <= ~ext_hold_q;
          end else if (i_wake) begin
            st_q      <= ST_SMR;
            o_stopped <= 1'b0;
          end
        end
        ST_SMR: begin
          // a reset cause during recovery still wins over the delay
          if (ext_hold_q || i_por_evt || i_bo_evt || i_wdt_evt) begin
            st_q       <= ST_RESET;
            o_sys_rst  <= 1'b1;
            int_pend_q <= ~ext_hold_q;
          end else if (!hold_busy) begin
            st_q      <= ST_RUN;
            o_cpu_rst <= 1'b0;
            // only watchdog and oscillator control change here
            o_wdt_ctl[`WDT_STOPREC_BIT] <= 1'b1;
            o_osc_ctl <= `OSC_CTL_RST;
          end
        end
        default: begin
          st_q <= ST_RESET;
        end
      endcase
      // register writes in run state only
      if (st_q == ST_RUN && i_osc_ctl_wr) begin
        o_osc_ctl <= i_osc_ctl_wdata;
      end
      if (st_q == ST_RUN && i_port_ctl_wr) begin
        if (i_port_addr == `SUB_ALT_FUNC) begin
          o_alt_func <= i_port_ctl_wdata;
        end else if (i_port_addr == `SUB_OPEN_DRAIN) begin
          o_open_drain <= i_port_ctl_wdata;
        end
      end
      // events landing with a software clear still stick
      if (i_por_evt) begin
        o_rst_cause[`CAUSE_POR_BIT] <= 1'b1;
      end
      if (i_bo_evt) begin
        o_rst_cause[`CAUSE_BO_BIT] <= 1'b1;
      end
      if (i_wdt_evt) begin
        o_rst_cause[`CAUSE_WDT_BIT] <= 1'b1;
      end
    end
  end

  // pin mux: alt vs gpio, open drain masks high drive, crystal override
  always @* begin
    pin_out_d = 8'h00;
    pin_oe_d  = 8'h00;
    begin : pin_loop
      integer k;
      for (k = 0; k < 8; k = k + 1) begin
        if (o_alt_func[k]) begin
          pin_out_d[k] = i_alt_out[k];
          pin_oe_d[k]  = i_alt_oe[k];
        end else begin
          pin_out_d[k] = i_gpio_out[k];
          pin_oe_d[k]  = ~i_gpio_dir_in[k];
        end
        // open drain: drive only a low, regardless of alt selection
        if (o_open_drain[k] && pin_out_d[k]) begin
          pin_oe_d[k] = 1'b0;
        end
      end
    end
    pin_oe_d = pin_oe_d & od_pin_mask;
    if (SMALL_PKG && o_dbg_unlocked) begin
      pin_oe_d[`PIN_DBG] = 1'b0;
    end
    // shared reset pin returns to reset function during reset
    if (SMALL_PKG && o_sys_rst) begin
      pin_oe_d[`PIN_RST]  = 1'b0;
      pin_out_d[`PIN_RST] = 1'b0;
    end
  end

  // registered outputs: pins, indicator, readback
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin_out        <= 8'h00;
      o_pin_oe         <= 8'h00;
      o_rst_pin_out    <= 1'b0;
      o_rst_pin_oe     <= 1'b1;
      o_port_ctl_rdata <= 8'h00;
    end else begin
      o_pin_out     <= pin_out_d;
      o_pin_oe      <= pin_oe_d;
      o_rst_pin_out <= 1'b0;
      // drive low only while a reset hold runs, then let go so that the pin
      // level shows whether an outside part still holds the line
      o_rst_pin_oe  <= ind_load | (hold_busy & (st_q != ST_SMR));
      if (i_port_addr == `SUB_ALT_FUNC) begin
        o_port_ctl_rdata <= o_alt_func;
      end else if (i_port_addr == `SUB_OPEN_DRAIN) begin
        o_port_ctl_rdata <= o_open_drain;
      end else begin
        o_port_ctl_rdata <= 8'h00;
      end
    end
  end
endmodule

/* reset_and_port_pin_control_chk.sv */
`timescale 1ns/1ps
`include "rstpin_defines.vh"
// watches sequencer and pin outputs from the top ports
module reset_and_port_pin_control_chk (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_rst_pin_in,
  input  wire logic       i_por_evt,
  input  wire logic       i_bo_evt,
  input  wire logic       i_wdt_evt,
  input  wire logic       i_stop_exec,
  input  wire logic       i_wake,
  input  wire logic       i_osc_tick,
  input  wire logic       o_sys_rst,
  input  wire logic       o_cpu_rst,
  input  wire logic       o_stopped,
  input  wire logic       o_rst_pin_oe,
  input  wire logic       o_dbg_req_bit,
  input  wire logic [7:0] o_osc_ctl,
  input  wire logic [7:0] o_open_drain,
  input  wire logic [7:0] o_pin_out,
  input  wire logic [7:0] o_pin_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [12:0] tick_q; // oscillator ticks since wake
  logic        rec_q;  // stop recovery in progress
  // counts only recovery ticks, so a normal reset exit is not judged
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_q <= 13'h0;
      rec_q  <= 1'b0;
    end else if (i_wake) begin
      tick_q <= 13'h0;
      rec_q  <= 1'b1;
    end else begin
      tick_q <= tick_q + {12'h0, i_osc_tick & o_cpu_rst};
      rec_q  <= rec_q & o_cpu_rst;
    end
  end
  rst_qual_a: assert property (!i_rst_pin_in [*4] |-> ##[0:2] o_sys_rst)
    else $error("reset pin low four cycles without reset");
  hold_low_a: assert property (o_sys_rst && !i_rst_pin_in |=> o_sys_rst)
    else $error("reset left while pin low");
  pin_ind_a: assert property ($rose(o_sys_rst) |-> ##[0:2] o_rst_pin_oe)
    else $error("reset indicator not driven");
  int_evt_a: assert property (i_por_evt || i_bo_evt || i_wdt_evt
    |=> o_sys_rst ##[0:1] o_rst_pin_oe [*3]) else $error("internal event hold wrong");
  dbg_clr_a: assert property (o_dbg_req_bit && o_sys_rst |-> ##[0:3] !o_dbg_req_bit)
    else $error("debugger request bit stuck");
  stop_enter_a: assert property (i_stop_exec && !o_sys_rst && !o_stopped
    |=> o_stopped && o_cpu_rst) else $error("stop not entered");
  stop_hold_a: assert property (rec_q && !o_cpu_rst
    |-> tick_q inside {13'd66, 13'd67, 13'd5000, 13'd5001}) else $error("recovery length wrong");
  xtal_ovr_a: assert property (o_osc_ctl[7] && $past(o_osc_ctl[7])
    |-> o_pin_oe[1:0] == 2'b00) else $error("crystal pins still driven");
  od_drive_a: assert property ($stable(o_open_drain)
    |-> (o_open_drain & o_pin_out & o_pin_oe) == 8'h00) else $error("open drain pin drives high");
  cover property ($fell(o_sys_rst));
  cover property (rec_q && !o_cpu_rst);
  cover property (o_osc_ctl[7] && o_stopped);
endmodule
bind reset_and_port_pin_control reset_and_port_pin_control_chk chk_u (.*);

/* rst_line_partner.sv */
`timescale 1ns/1ps
// board parts sharing the active-low reset line, with a pull-up
module rst_line_partner (
  input  wire logic i_dut_oe, // device pulls the line low
  input  wire logic i_press,  // bench command to hold the line low
  output wire logic o_line    // resolved line level
);
  // pulls low only on command, never on its own during a reset
  assign o_line = !(i_dut_oe || i_press);
endmodule

/* reset_and_port_pin_control_tb_top.sv */
`timescale 1ns/1ps
`include "rstpin_defines.vh"
// drives at falling edges, compares with integer models
module reset_and_port_pin_control_tb_top;
  logic       i_clk = 1'b0, i_rst = 1'b1, i_por_evt = 1'b0, i_bo_evt = 1'b0;
  logic       i_wdt_evt = 1'b0, i_dbg_rst_wr = 1'b0, i_stop_exec = 1'b0, i_wake = 1'b0;
  logic       i_osc_tick = 1'b0, i_unlock_seen = 1'b0, i_port_ctl_wr = 1'b0;
  logic       i_osc_ctl_wr = 1'b0, i_flag_clr = 1'b0, press = 1'b0;
  logic [7:0] i_port_addr = 8'h00, i_port_ctl_wdata = 8'h00, i_osc_ctl_wdata = 8'h00;
  logic [7:0] i_gpio_out = 8'h00, i_gpio_dir_in = 8'hff, i_alt_out = 8'h00, i_alt_oe = 8'h00;
  wire        i_rst_pin_in;
  logic       o_sys_rst, o_cpu_rst, o_stopped, o_rst_pin_out, o_rst_pin_oe;
  logic       o_dbg_req_bit, o_dbg_unlocked;
  logic [7:0] o_wdt_ctl, o_rst_cause, o_osc_ctl, o_alt_func, o_open_drain, o_port_ctl_rdata;
  logic [7:0] o_pin_out, o_pin_oe, v, out_e, oe_e;
  integer     miscompares = 0, n_checks = 0, alt_m, od_m, k;
  // short hold delays keep the run brief
  reset_and_port_pin_control #(.POR_HOLD(13'd4), .BO_HOLD(13'd4), .WDT_HOLD(13'd4)) dut_u (.*);
  rst_line_partner line_u (.i_dut_oe(o_rst_pin_oe), .i_press(press), .o_line(i_rst_pin_in));
  always #4 i_clk = ~i_clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // bounded wait for both resets to drop
  task automatic wait_run;
    for (int n = 0; o_sys_rst !== 1'b0 || o_cpu_rst !== 1'b0; n++) begin
      if (n > 6000) begin
        miscompares++;
        stop_test();
      end
      @(negedge i_clk);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_port_addr = a;
    i_port_ctl_wdata = d;
    i_port_ctl_wr = 1'b1;
    @(negedge i_clk);
    i_port_ctl_wr = 1'b0;
    @(negedge i_clk);
  endtask
  // read data follows the address by one edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    i_port_addr = a;
    @(negedge i_clk);
    d = o_port_ctl_rdata;
  endtask
  task automatic clr_flags;
    i_flag_clr = 1'b1;
    @(negedge i_clk);
    i_flag_clr = 1'b0;
  endtask
  // stop, wake, then tick every cycle until the core runs
  task automatic stop_recover(input integer n);
    integer c;
    i_stop_exec = 1'b1;
    @(negedge i_clk);
    i_stop_exec = 1'b0;
    chk({7'h0, o_stopped}, 8'h01);
    repeat (3) @(negedge i_clk);
    i_wake = 1'b1;
    @(negedge i_clk);
    i_wake = 1'b0;
    i_osc_tick = 1'b1;
    for (c = 0; o_cpu_rst !== 1'b0 && c < 6000; c++) @(negedge i_clk);
    i_osc_tick = 1'b0;
    chk({7'h0, c >= n && c <= n + 2}, 8'h01);
    if (c >= 6000) begin
      miscompares++;
      stop_test();
    end
  endtask
  initial begin
    void'($urandom(89061));
    repeat (4) @(negedge i_clk);
    i_rst = 1'b0;
    wait_run();
    chk(o_alt_func, `ALT_FUNC_RST_SMALL);
    chk(o_open_drain, `OPEN_DRAIN_RST);
    $display("reset values done");
    for (k = 0; k < 4; k++) begin
      alt_m = $urandom & 8'hff;
      od_m = $urandom & 8'hff;
      {i_gpio_out, i_gpio_dir_in, i_alt_out, i_alt_oe} = $urandom;
      wr(`SUB_ALT_FUNC, alt_m[7:0]);
      wr(`SUB_OPEN_DRAIN, od_m[7:0]);
      wr(8'h05, 8'hff);
      rd(`SUB_ALT_FUNC, v);
      chk(v, alt_m[7:0]);
      rd(`SUB_OPEN_DRAIN, v);
      chk(v, od_m[7:0]);
      rd(8'h05, v);
      chk(v, 8'h00);
      out_e = (alt_m[7:0] & i_alt_out) | (~alt_m[7:0] & i_gpio_out);
      oe_e = ((alt_m[7:0] & i_alt_oe) | (~alt_m[7:0] & ~i_gpio_dir_in)) & ~(od_m[7:0] & out_e);
      chk(o_pin_oe & 8'hf8, oe_e & 8'hf8);
      chk(o_pin_out & oe_e & 8'hf8, out_e & oe_e & 8'hf8);
    end
    $display("port registers done");
    i_osc_ctl_wdata = 8'h80;
    i_osc_ctl_wr = 1'b1;
    @(negedge i_clk);
    i_osc_ctl_wr = 1'b0;
    repeat (2) @(negedge i_clk);
    chk(o_pin_oe & 8'h03, 8'h00);
    stop_recover(5000);
    chk(o_osc_ctl, `OSC_CTL_RST);
    chk(o_alt_func, alt_m[7:0]);
    chk(o_open_drain, od_m[7:0]);
    chk({7'h0, o_wdt_ctl[`WDT_STOPREC_BIT]}, 8'h01);
    stop_recover(66);
    $display("stop recovery done");
    clr_flags();
    press = 1'b1;
    repeat (2) @(negedge i_clk);
    press = 1'b0;
    repeat (4) @(negedge i_clk);
    chk({7'h0, o_sys_rst}, 8'h00);
    i_unlock_seen = 1'b1;
    press = 1'b1;
    repeat (5) @(negedge i_clk);
    chk({5'h0, o_rst_pin_out, o_sys_rst, o_rst_pin_oe}, 8'h03);
    repeat (25) @(negedge i_clk);
    chk({7'h0, o_sys_rst}, 8'h01);
    press = 1'b0;
    wait_run();
    i_unlock_seen = 1'b0;
    chk({7'h0, o_wdt_ctl[`WDT_EXT_BIT]}, 8'h01);
    chk(o_alt_func, `ALT_FUNC_RST_SMALL);
    chk({7'h0, o_dbg_unlocked}, 8'h01);
    $display("external reset done");
    clr_flags();
    i_dbg_rst_wr = 1'b1;
    @(negedge i_clk);
    i_dbg_rst_wr = 1'b0;
    chk({7'h0, o_dbg_req_bit}, 8'h01);
    @(negedge i_clk);
    chk({7'h0, o_sys_rst}, 8'h01);
    wait_run();
    chk({o_rst_cause[`CAUSE_POR_BIT], o_dbg_req_bit, 6'h0}, 8'h80);
    chk({7'h0, o_dbg_unlocked}, 8'h01);
    $display("debugger reset done");
    for (k = 0; k < 3; k++) begin
      clr_flags();
      {i_por_evt, i_bo_evt, i_wdt_evt} = 3'b100 >> k;
      @(negedge i_clk);
      {i_por_evt, i_bo_evt, i_wdt_evt} = 3'b000;
      chk({7'h0, o_sys_rst}, 8'h01);
      @(negedge i_clk);
      chk({7'h0, o_rst_pin_oe}, 8'h01);
      wait_run();
      chk(o_rst_cause & 8'hb8, k == 0 ? 8'h80 : (k == 1 ? 8'h08 : 8'h20));
    end
    chk({7'h0, o_dbg_unlocked}, 8'h00);
    $display("internal events done");
    stop_test();
  end
endmodule
